// File: rtl/flash_cmd_pkg.sv
// Shared constants and types for both ends of the flash command link
`default_nettype none

package flash_cmd_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCK_PERIOD_NS = 320;
	localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [1:0] SCK_HALF_LAST = 2'(SCK_HALF_CYC - 1);
	// Recovery after software reset, program case longer
	localparam int REC_PROG_US = 20;
	localparam int REC_OTHER_US = 2;
	localparam int REC_PROG_CYC = REC_PROG_US * CLK_MHZ;
	localparam int REC_OTHER_CYC = REC_OTHER_US * CLK_MHZ;
	localparam int REC_W = 10;
	localparam logic [REC_W-1:0] REC_PROG_CNT = REC_W'(REC_PROG_CYC);
	localparam logic [REC_W-1:0] REC_OTHER_CNT = REC_W'(REC_OTHER_CYC);

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_PROTECT_MODE_SELECT = 8'h68;
	localparam logic [7:0] OP_SINGLE_BLOCK_LOCK = 8'h36;
	localparam logic [7:0] OP_SINGLE_BLOCK_UNLOCK = 8'h39;
	localparam logic [7:0] OP_READ_BLOCK_LOCK_STATE = 8'h3C;
	localparam logic [7:0] OP_ALL_BLOCK_LOCK = 8'h7E;
	localparam logic [7:0] OP_ALL_BLOCK_UNLOCK = 8'h98;
	localparam logic [7:0] OP_READ_PARAM_TABLE = 8'h5A;
	localparam logic [7:0] OP_BUSY_ON_OUTPUT_ENABLE = 8'h70;
	localparam logic [7:0] OP_BUSY_ON_OUTPUT_DISABLE = 8'h80;
	localparam logic [7:0] OP_IDLE_COMMAND = 8'h00;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_RESET_EXECUTE = 8'h99;

	// ------------------------------------------------------------------
	// Frame layout and array geometry
	// ------------------------------------------------------------------
	localparam logic [2:0] NB_OPCODE_ONLY = 3'h1;
	localparam logic [2:0] NB_OPCODE_ADDR = 3'h4;
	localparam logic [2:0] BYTE_IDX_ADDR_LAST = 3'h3;
	localparam logic [2:0] BYTE_IDX_DUMMY = 3'h4;
	localparam logic [2:0] BYTE_IDX_MAX = 3'h7;
	localparam int BLK_MSB = 21;
	localparam int BLK_LSB = 16;
	localparam int BLOCK_COUNT = 64;
	localparam logic [3:0] LEVEL_ALL = 4'h7;
	localparam logic [6:0] LEVEL_SPAN_ALL = 7'h40;
	localparam int SEC_MODE_BIT = 7;
	localparam int SEC_CP_BIT = 4;
	localparam int PARAM_DEPTH = 8;
	localparam logic [7:0] PARAM_BLANK = 8'hFF;
	localparam logic [7:0] PARAM_TABLE [PARAM_DEPTH] = '{
		8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF
	};

	// ------------------------------------------------------------------
	// Host register map on APB
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0C;
	localparam int CTRL_NTX_LSB = 8;
	localparam int CTRL_NRX_LSB = 12;

	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_SCK_LO,
		HOST_SCK_HI,
		HOST_TAIL
	} host_state_e;

endpackage

`default_nettype wire

// File: rtl/flash_link_if.sv
// Serial link between the host controller and the flash command logic
`default_nettype none

interface flash_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;

	modport device (
		input cs_n,
		input sck,
		input si,
		output so,
		output so_oe
	);

	modport host (
		output cs_n,
		output sck,
		output si,
		input so
	);
endinterface

`default_nettype wire

// File: rtl/flash_cmd_device.sv
// Flash protection, reset and parameter-read command logic (device end)
`default_nettype none

module flash_cmd_device
	import flash_cmd_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	flash_link_if.device link,
	input wire logic wp_n,
	input wire logic nv_protect_mode,
	input wire logic status_write_guard,
	input wire logic [3:0] level_protect_bits,
	input wire logic continuous_program_mode,
	input wire logic array_busy,
	input wire logic busy_is_program,
	input wire logic [23:0] check_addr,
	output logic check_protected,
	output logic level_bits_writable,
	output logic protect_mode,
	output logic protect_mode_program,
	output logic [7:0] security_status,
	output logic reset_abort,
	output logic recovering
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sck_sy, cs_sy, bit_cnt, byte_cnt, out_bits, tbl_idx;
		logic [1:0] si_sy, wp_sy;
		logic [7:0] shift, opcode, out_shift, sec;
		logic [23:0] addr;
		logic [BLOCK_COUNT-1:0] locks;
		logic [REC_W-1:0] rec_cnt;
		logic loaded, framed, out_on, tbl_blank, wel, protect_mode_select, busy_en;
		logic rst_armed, abort, mode_prog, prot, lvl_wr, so, so_oe;
	} dev_s;
	dev_s state_reg;
	dev_s state_next;
	// Level scheme: protects the top 2^(bp-1) blocks, all from 7 up
	function automatic logic level_hit(input logic [3:0] bp,
		input logic [5:0] blk);
		logic [6:0] span;
		span = 7'h00;
		if (bp >= LEVEL_ALL) begin
			span = LEVEL_SPAN_ALL;
		end else if (bp != 4'h0) begin
			span = 7'h01 << (bp - 4'h1);
		end
		return {1'b0, ~blk} < span;
	endfunction
	// Only the scheme picked by the mode bit governs
	function automatic logic protect_of(input dev_s s,
		input logic [23:0] a, input logic [3:0] bp);
		if (s.protect_mode_select) begin
			return ~s.wp_sy[1] | s.locks[a[BLK_MSB:BLK_LSB]];
		end
		return level_hit(bp, a[BLK_MSB:BLK_LSB]);
	endfunction
	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic sck_rise, sck_fall, cs_low, cs_fall, cs_rise, boundary, armed;
		logic [7:0] in_byte, ld;
		state_next = state_reg;
		state_next.abort = 1'b0;
		state_next.mode_prog = 1'b0;
		// Pins pass two flops; the third stage only finds edges
		state_next.sck_sy = {state_reg.sck_sy[1:0], link.sck};
		state_next.cs_sy = {state_reg.cs_sy[1:0], link.cs_n};
		state_next.si_sy = {state_reg.si_sy[0], link.si};
		state_next.wp_sy = {state_reg.wp_sy[0], wp_n};
		sck_rise = state_reg.sck_sy[1] & ~state_reg.sck_sy[2];
		sck_fall = ~state_reg.sck_sy[1] & state_reg.sck_sy[2];
		cs_low = ~state_reg.cs_sy[1];
		cs_fall = ~state_reg.cs_sy[1] & state_reg.cs_sy[2];
		cs_rise = state_reg.cs_sy[1] & ~state_reg.cs_sy[2];
		boundary = state_reg.bit_cnt == 3'h0;
		in_byte = {state_reg.shift[6:0], state_reg.si_sy[1]};
		ld = PARAM_BLANK;
		armed = 1'b0;
		// Power-on: take stored mode bit, lock every block
		if (!state_reg.loaded) begin
			state_next.loaded = 1'b1;
			state_next.protect_mode_select = nv_protect_mode;
			state_next.locks = '1;
		end
		if (state_reg.rec_cnt != '0)
			state_next.rec_cnt = state_reg.rec_cnt - 1'b1;
		// Frames opening during reset recovery are ignored whole
		if (cs_fall && state_reg.rec_cnt == '0) begin
			state_next.framed = 1'b1;
		end
		if (!cs_low) begin
			state_next.bit_cnt = 3'h0;
			state_next.byte_cnt = 3'h0;
			state_next.out_on = 1'b0;
		end
		// Input bits on rising edges, MSB first
		if (cs_low && state_reg.framed && sck_rise) begin
			state_next.shift = in_byte;
			state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
			if (state_reg.bit_cnt == 3'h7) begin
				if (state_reg.byte_cnt == 3'h0) begin
					state_next.opcode = in_byte;
				end else if (state_reg.byte_cnt <= BYTE_IDX_ADDR_LAST) begin
					state_next.addr = {state_reg.addr[15:0], in_byte};
				end
				if (state_reg.byte_cnt != BYTE_IDX_MAX) begin
					state_next.byte_cnt = state_reg.byte_cnt + 3'h1;
				end
				if (state_reg.opcode == OP_READ_BLOCK_LOCK_STATE &&
					state_reg.byte_cnt == BYTE_IDX_ADDR_LAST &&
					state_reg.protect_mode_select) begin
					state_next.out_on = 1'b1;
					state_next.out_bits = 3'h0;
				end
				if (state_reg.opcode == OP_READ_PARAM_TABLE &&
					state_reg.byte_cnt == BYTE_IDX_DUMMY) begin
					state_next.out_on = 1'b1;
					state_next.out_bits = 3'h0;
					state_next.tbl_idx = state_reg.addr[2:0];
					state_next.tbl_blank = |state_reg.addr[23:3];
				end
			end
		end
		// Output bits change on falling edges, a fresh byte every eight
		if (cs_low && state_reg.out_on && sck_fall) begin
			state_next.out_bits = state_reg.out_bits + 3'h1;
			if (state_reg.out_bits == 3'h0) begin
				if (state_reg.opcode == OP_READ_BLOCK_LOCK_STATE) begin
					ld = {7'h00, protect_of(state_reg, state_reg.addr,
						level_protect_bits)};
				end else begin
					if (!state_reg.tbl_blank) begin
						ld = PARAM_TABLE[state_reg.tbl_idx];
					end
					state_next.tbl_idx = state_reg.tbl_idx + 3'h1;
					if (state_reg.tbl_idx == 3'h7) begin
						state_next.tbl_blank = 1'b1;
					end
				end
				state_next.out_shift = ld;
				state_next.so = ld[7];
			end else begin
				state_next.out_shift = {state_reg.out_shift[6:0], 1'b0};
				state_next.so = state_reg.out_shift[6];
			end
		end
		// Command execution when chip select rises
		if (cs_rise && state_reg.framed) begin
			state_next.framed = 1'b0;
			unique case (state_reg.opcode)
				OP_WRITE_LATCH_SET: begin
					if (state_reg.byte_cnt == NB_OPCODE_ONLY) begin
						state_next.wel = 1'b1;
					end
				end
				OP_PROTECT_MODE_SELECT: begin
					if (state_reg.byte_cnt == NB_OPCODE_ONLY && state_reg.wel) begin
						state_next.protect_mode_select = 1'b1;
						state_next.mode_prog = 1'b1;
						state_next.wel = 1'b0;
					end
				end
				OP_SINGLE_BLOCK_LOCK, OP_SINGLE_BLOCK_UNLOCK: begin
					if (boundary && state_reg.byte_cnt == NB_OPCODE_ADDR &&
						state_reg.wel && state_reg.protect_mode_select) begin
						state_next.locks[state_reg.addr[BLK_MSB:BLK_LSB]] =
							state_reg.opcode == OP_SINGLE_BLOCK_LOCK;
						state_next.wel = 1'b0;
					end
				end
				OP_ALL_BLOCK_LOCK, OP_ALL_BLOCK_UNLOCK: begin
					if (boundary && state_reg.byte_cnt == NB_OPCODE_ONLY &&
						state_reg.wel && state_reg.protect_mode_select) begin
						state_next.locks = {BLOCK_COUNT{state_reg.opcode ==
							OP_ALL_BLOCK_LOCK}};
						state_next.wel = 1'b0;
					end
				end
				OP_BUSY_ON_OUTPUT_ENABLE, OP_BUSY_ON_OUTPUT_DISABLE: begin
					if (boundary && state_reg.byte_cnt == NB_OPCODE_ONLY) begin
						state_next.busy_en = state_reg.opcode ==
							OP_BUSY_ON_OUTPUT_ENABLE;
					end
				end
				OP_RESET_ARM: armed = state_reg.byte_cnt == NB_OPCODE_ONLY;
				OP_RESET_EXECUTE: begin
					if (state_reg.rst_armed &&
						state_reg.byte_cnt == NB_OPCODE_ONLY) begin
						state_next.abort = 1'b1;
						state_next.wel = 1'b0;
						state_next.busy_en = 1'b0;
						state_next.rec_cnt = busy_is_program ? REC_PROG_CNT :
							REC_OTHER_CNT;
					end
				end
				default: ;
			endcase
			// Any frame other than a lone arm disarms, idle included
			state_next.rst_armed = armed;
		end
		// Output pin: read data in a frame, ready/busy outside one
		if (cs_low) begin
			state_next.so_oe = state_reg.out_on && state_reg.framed &&
				(state_reg.out_bits != 3'h0 || state_reg.so_oe);
		end else begin
			state_next.so_oe = state_reg.busy_en && continuous_program_mode;
			state_next.so = ~array_busy;
		end
		if (cs_low && state_reg.out_on && sck_fall) begin
			state_next.so_oe = 1'b1;
		end
		// Registered status for the array side
		state_next.prot = protect_of(state_reg, check_addr,
			level_protect_bits);
		state_next.lvl_wr = ~(status_write_guard & ~state_reg.wp_sy[1]);
		state_next.sec = 8'h00;
		state_next.sec[SEC_MODE_BIT] = state_reg.protect_mode_select;
		state_next.sec[SEC_CP_BIT] = continuous_program_mode;
		if (srst) begin
			state_next = '0;
			state_next.cs_sy = 3'h7;
			state_next.wp_sy = 2'h3; // Pin idles high, no false protect
			state_next.locks = '1;
		end
	end
	// ------------------------------------------------------------------
	// Registers and outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		state_reg <= state_next;
	end
	assign link.so = state_reg.so;
	assign link.so_oe = state_reg.so_oe;
	assign check_protected = state_reg.prot;
	assign level_bits_writable = state_reg.lvl_wr;
	assign protect_mode = state_reg.protect_mode_select;
	assign protect_mode_program = state_reg.mode_prog;
	assign security_status = state_reg.sec;
	assign reset_abort = state_reg.abort;
	assign recovering = state_reg.rec_cnt != '0;
endmodule // flash_cmd_device

`default_nettype wire

// File: rtl/flash_cmd_host.sv
// Host serial controller, ordered over APB
`default_nettype none

module flash_cmd_host
	import flash_cmd_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	flash_link_if.host link
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		host_state_e st;
		logic [1:0] div;
		logic [6:0] bits;
		logic [39:0] tx;
		logic [31:0] rx;
		logic [23:0] addr;
		logic [1:0] so_sy;
		logic [31:0] rdata;
		logic err;
		logic cs_n;
		logic sck;
		logic si;
	} host_s;

	host_s state_reg;
	host_s state_next;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic tick;
		logic wr;
		logic setup;
		logic [2:0] ntx;
		logic [2:0] nrx;
		state_next = state_reg;
		state_next.so_sy = {state_reg.so_sy[0], link.so};
		tick = state_reg.div == SCK_HALF_LAST;
		state_next.div = tick ? 2'h0 : state_reg.div + 2'h1;
		wr = psel && penable && pwrite;
		setup = psel && !penable;
		ntx = pwdata[CTRL_NTX_LSB +: 3];
		nrx = pwdata[CTRL_NRX_LSB +: 3];

		// Read data latched in setup so it stands through access
		if (setup) begin
			state_next.err = 1'b0;
			state_next.rdata = 32'h0000_0000;
			unique case (paddr)
				OFS_CTRL: begin
				end
				OFS_ADDR: state_next.rdata = {8'h00, state_reg.addr};
				OFS_STATUS: state_next.rdata = {31'h0, state_reg.st != HOST_IDLE};
				OFS_RXDATA: state_next.rdata = state_reg.rx;
				default: state_next.err = 1'b1;
			endcase
		end

		if (wr && paddr == OFS_ADDR) begin
			state_next.addr = pwdata[23:0];
		end
		// A new frame only from idle; control writes while busy are dropped, address writes are taken
		if (wr && paddr == OFS_CTRL && state_reg.st == HOST_IDLE) begin
			state_next.tx = {pwdata[7:0], state_reg.addr, 8'h00};
			state_next.bits = 7'((4'h1 + 4'(ntx) + 4'(nrx)) * 7'h08);
			state_next.rx = 32'h0000_0000;
			state_next.cs_n = 1'b0;
			state_next.si = pwdata[7];
			state_next.div = 2'h0;
			state_next.st = HOST_SCK_LO;
		end

		// Bit engine: one bit per 8 clocks, MSB first
		unique case (state_reg.st)
			HOST_IDLE: begin
			end
			HOST_SCK_LO: begin
				if (tick) begin
					state_next.sck = 1'b1;
					state_next.st = HOST_SCK_HI;
				end
			end
			HOST_SCK_HI: begin
				if (tick) begin
					state_next.sck = 1'b0;
					state_next.rx = {state_reg.rx[30:0], state_reg.so_sy[1]};
					state_next.bits = state_reg.bits - 7'h01;
					state_next.tx = {state_reg.tx[38:0], 1'b0};
					state_next.si = state_reg.tx[38];
					state_next.st = state_reg.bits == 7'h01 ? HOST_TAIL :
						HOST_SCK_LO;
				end
			end
			HOST_TAIL: begin
				if (tick) begin
					state_next.cs_n = 1'b1;
					state_next.si = 1'b0;
					state_next.st = HOST_IDLE;
				end
			end
		endcase

		if (srst) begin
			state_next = '0;
			state_next.st = HOST_IDLE;
			state_next.cs_n = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Registers and outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		state_reg <= state_next;
	end

	assign prdata = state_reg.rdata;
	assign pslverr = state_reg.err && psel && penable;
	assign pready = psel && penable; // No wait states
	assign link.cs_n = state_reg.cs_n;
	assign link.sck = state_reg.sck;
	assign link.si = state_reg.si;

endmodule // flash_cmd_host

`default_nettype wire

// File: tb/flash_cmd_monitor.sv
// Wire-level checks on the serial link between host and device ends
`default_nettype none

module flash_cmd_monitor (
	input wire logic clock,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Frame bookkeeping
	// ------------------------------------------------------------
	logic [7:0] n_edge;
	logic [3:0] n_low;

	// Counts sck rises and settle time of the frame in progress
	always_ff @(posedge clock) begin
		if (srst || cs_n) begin
			n_edge <= 8'h00;
			n_low <= 4'h0;
		end else begin
			if ($rose(sck))
				n_edge <= n_edge + 8'h01;
			if (n_low != 4'hF) // Saturates: only settle time matters
				n_low <= n_low + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	sequence half_high;
		sck [*4] ##1 !sck;
	endsequence
	sequence half_low;
		!sck [*4];
	endsequence

	a_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("sck moved outside a frame");
	a_si_hold_high: assert property (sck && $past(sck) |-> $stable(si))
		else $error("si changed while sck high");
	a_sck_high_half: assert property ($rose(sck) |-> half_high)
		else $error("sck high half not four clocks");
	a_sck_low_half: assert property ($fell(sck) |-> half_low)
		else $error("sck low half too short");
	a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("chip select gap too short");
	a_cs_byte_edge: assert property ($rose(cs_n) |->
		n_edge[2:0] == 3'h0 && n_edge != 8'h00)
		else $error("chip select rose off a byte boundary");
	a_so_quiet_input: assert property (!cs_n && n_low == 4'hF &&
		n_edge < 8'h20 |-> !so_oe)
		else $error("so driven before input bytes done");
	a_so_bit_steady: assert property (!cs_n && sck && $past(sck) &&
		so_oe && $past(so_oe) |-> $stable(so))
		else $error("so changed inside sck high half");
	a_reset_idle_state: assert property ($fell(srst) |->
		cs_n && !sck && !so_oe)
		else $error("link not idle after reset");
endmodule // flash_cmd_monitor

`default_nettype wire

// File: tb/flash_protect_reset_cmd_logic_test.sv
// Self-checking bench joining host and device ends of the flash link
`default_nettype none

module flash_protect_reset_cmd_logic_test import flash_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic wp_n = 1'b1;
	logic nv = 1'b0;
	logic guard = 1'b0;
	logic cpm = 1'b0;
	logic abusy = 1'b0;
	logic bprog = 1'b0;
	logic [3:0] bp = 4'h0;
	logic [23:0] caddr = 24'h0;
	logic prot, lbw, pmode, pprog, rabort, recov;
	logic [7:0] sec;
	logic [31:0] r;
	logic e;
	int n_errors = 0;
	int total_checks = 0;
	int n_prog = 0;
	int n_abort = 0;
	int rec_len = 0;

	always #20 clock = ~clock;

	// Pulses are one cycle wide, so count them as they pass
	always @(posedge clock) begin
		if (pprog === 1'b1) n_prog++;
		if (rabort === 1'b1) n_abort++;
		if (recov === 1'b1) rec_len++;
	end

	// ------------------------------------------------------------
	// Both ends across one link, monitor beside it
	// ------------------------------------------------------------
	flash_link_if i_flash_link_if ();
	flash_cmd_host i_flash_cmd_host (.clock(clock), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(i_flash_link_if));
	flash_cmd_device i_flash_cmd_device (.clock(clock), .srst(srst),
		.link(i_flash_link_if), .wp_n(wp_n), .nv_protect_mode(nv),
		.status_write_guard(guard), .level_protect_bits(bp),
		.continuous_program_mode(cpm), .array_busy(abusy),
		.busy_is_program(bprog), .check_addr(caddr),
		.check_protected(prot), .level_bits_writable(lbw),
		.protect_mode(pmode), .protect_mode_program(pprog),
		.security_status(sec), .reset_abort(rabort),
		.recovering(recov));
	flash_cmd_monitor i_flash_cmd_monitor (.clock(clock), .srst(srst),
		.cs_n(i_flash_link_if.cs_n), .sck(i_flash_link_if.sck),
		.si(i_flash_link_if.si), .so(i_flash_link_if.so),
		.so_oe(i_flash_link_if.so_oe));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One APB transfer; holds the request until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Whole frame: order it, poll busy, let the device act, fetch rx
	task frame(input logic [7:0] op, input logic [2:0] nt,
		input logic [2:0] nr, input logic [23:0] a);
		apb(1'b1, OFS_ADDR, {8'h00, a});
		apb(1'b1, OFS_CTRL, {17'h0, nr, 1'b0, nt, op});
		repeat (4) @(posedge clock);
		r = 32'h1;
		while (r[0] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
		repeat (12) @(posedge clock);
		apb(1'b0, OFS_RXDATA, 32'h0);
	endtask

	task write_latch_set;
		frame(OP_WRITE_LATCH_SET, 3'h0, 3'h0, 24'h0);
	endtask

	// Query array protection at an address
	task blk(input logic [23:0] a);
		caddr <= a;
		repeat (3) @(posedge clock);
	endtask

	// Mid-run reset; drops a leftover write latch, as a software reset also does
	task pulse_reset;
		srst <= 1'b1;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	function automatic logic near(input int n, input int want);
		return n >= want - 5 && n <= want + 5;
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_level;
		check(32'(pmode), 32'h0);
		check(32'(sec), 32'h0);
		bp <= LEVEL_ALL;
		blk(24'h3F_0000);
		check(32'(prot), 32'h1);
		bp <= 4'h0;
		write_latch_set;
		frame(OP_SINGLE_BLOCK_LOCK, 3'h3, 3'h0, 24'h3F_0000);
		blk(24'h3F_0000);
		check(32'(prot), 32'h0);
		guard <= 1'b1;
		wp_n <= 1'b0;
		repeat (6) @(posedge clock);
		check(32'(lbw), 32'h0);
		guard <= 1'b0;
		wp_n <= 1'b1;
		apb(1'b0, 8'h40, 32'h0);
		check(32'(e), 32'h1);
		$display("t_level done");
	endtask

	task t_select;
		pulse_reset; // Refused lock in t_level left the latch set
		frame(OP_PROTECT_MODE_SELECT, 3'h0, 3'h0, 24'h0);
		check(32'(pmode), 32'h0);
		write_latch_set;
		frame(OP_PROTECT_MODE_SELECT, 3'h0, 3'h0, 24'h0);
		check(32'(pmode), 32'h1);
		check(32'(sec[SEC_MODE_BIT]), 32'h1);
		check(32'(n_prog), 32'h1);
		nv <= 1'b1;
		pulse_reset;
		check(32'(pmode), 32'h1);
		blk(24'h00_0000);
		check(32'(prot), 32'h1);
		blk(24'h3F_F000);
		check(32'(prot), 32'h1);
		$display("t_select done");
	endtask

	task t_lock;
		write_latch_set;
		frame(OP_SINGLE_BLOCK_UNLOCK, 3'h3, 3'h0, 24'h05_3000);
		blk(24'h05_0000);
		check(32'(prot), 32'h0);
		blk(24'h06_0000);
		check(32'(prot), 32'h1);
		bp <= LEVEL_ALL;
		blk(24'h05_0000);
		check(32'(prot), 32'h0);
		bp <= 4'h0;
		frame(OP_READ_BLOCK_LOCK_STATE, 3'h3, 3'h1, 24'h05_0000);
		check(32'(r[0]), 32'h0);
		frame(OP_READ_BLOCK_LOCK_STATE, 3'h3, 3'h1, 24'h06_0000);
		check(32'(r[0]), 32'h1);
		wp_n <= 1'b0;
		blk(24'h05_0000);
		repeat (4) @(posedge clock);
		check(32'(prot), 32'h1);
		wp_n <= 1'b1;
		frame(OP_SINGLE_BLOCK_LOCK, 3'h3, 3'h0, 24'h05_0000);
		blk(24'h05_0000);
		check(32'(prot), 32'h0);
		write_latch_set;
		frame(OP_SINGLE_BLOCK_LOCK, 3'h2, 3'h0, 24'h05_0000);
		blk(24'h05_0000);
		check(32'(prot), 32'h0);
		frame(OP_SINGLE_BLOCK_LOCK, 3'h3, 3'h0, 24'h05_0000);
		blk(24'h05_0000);
		check(32'(prot), 32'h1);
		write_latch_set;
		frame(OP_ALL_BLOCK_UNLOCK, 3'h0, 3'h0, 24'h0);
		blk(24'h28_0000);
		check(32'(prot), 32'h0);
		write_latch_set;
		frame(OP_ALL_BLOCK_LOCK, 3'h0, 3'h0, 24'h0);
		blk(24'h28_0000);
		check(32'(prot), 32'h1);
		$display("t_lock done");
	endtask

	task t_param;
		frame(OP_READ_PARAM_TABLE, 3'h4, 3'h4, 24'h0);
		check(r, {PARAM_TABLE[0], PARAM_TABLE[1], PARAM_TABLE[2],
			PARAM_TABLE[3]});
		frame(OP_READ_PARAM_TABLE, 3'h4, 3'h2, 24'h6);
		check(32'(r[15:0]), {16'h0, PARAM_TABLE[6], PARAM_TABLE[7]});
		frame(OP_READ_PARAM_TABLE, 3'h4, 3'h1, 24'h9);
		check(32'(r[7:0]), 32'(PARAM_BLANK));
		$display("t_param done");
	endtask

	task t_busy;
		cpm <= 1'b1;
		abusy <= 1'b1;
		frame(OP_BUSY_ON_OUTPUT_ENABLE, 3'h0, 3'h0, 24'h0);
		check(32'(sec[SEC_CP_BIT]), 32'h1);
		check(32'(i_flash_link_if.so_oe), 32'h1);
		check(32'(i_flash_link_if.so), 32'h0);
		abusy <= 1'b0;
		repeat (4) @(posedge clock);
		check(32'(i_flash_link_if.so), 32'h1);
		frame(OP_BUSY_ON_OUTPUT_DISABLE, 3'h0, 3'h0, 24'h0);
		check(32'(i_flash_link_if.so_oe), 32'h0);
		cpm <= 1'b0;
		$display("t_busy done");
	endtask

	task t_reset;
		abusy <= 1'b1;
		bprog <= 1'b1;
		frame(OP_RESET_ARM, 3'h0, 3'h0, 24'h0);
		frame(OP_IDLE_COMMAND, 3'h0, 3'h0, 24'h0);
		frame(OP_RESET_EXECUTE, 3'h0, 3'h0, 24'h0);
		check(32'(n_abort), 32'h0);
		frame(OP_RESET_ARM, 3'h0, 3'h0, 24'h0);
		rec_len = 0;
		frame(OP_RESET_EXECUTE, 3'h0, 3'h0, 24'h0);
		repeat (600) @(posedge clock);
		check(32'(n_abort), 32'h1);
		check(32'(near(rec_len, REC_PROG_CYC)), 32'h1);
		bprog <= 1'b0;
		frame(OP_RESET_ARM, 3'h0, 3'h0, 24'h0);
		rec_len = 0;
		frame(OP_RESET_EXECUTE, 3'h0, 3'h0, 24'h0);
		repeat (600) @(posedge clock);
		check(32'(near(rec_len, REC_OTHER_CYC)), 32'h1);
		check(32'(recov), 32'h0);
		abusy <= 1'b0;
		$display("t_reset done");
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
		t_level;
		t_select;
		t_lock;
		t_param;
		t_busy;
		t_reset;
		end_of_test;
	end

	// Over ten times the expected run length
	initial begin
		#(CLK_PERIOD_NS * 90000);
		n_errors++;
		end_of_test;
	end
endmodule // flash_protect_reset_cmd_logic_test

`default_nettype wire
